/* smsp_port.sv */
// Byte-wide synchronous serial port with master or slave role and a small register port.
// Assumes a single 200 MHz ref_clk; pin inputs are asynchronous and are synchronised here.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/100ps
`include "smsp_params.svh"

module smsp_port
  import smsp_pkg::*;
#(
  parameter int SYNC_STAGES = 2
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire smsp_pkg::smsp_addr_t regAddr,
  input  wire smsp_pkg::smsp_byte_t regWdata,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic [7:0]             regRdata,
  output logic                   irq,
  input  wire logic              sckIn,
  output logic                   sckOut,
  output logic                   sckOen_n,
  input  wire logic              mosiIn,
  output logic                   mosiOut,
  output logic                   mosiOen_n,
  input  wire logic              misoIn,
  output logic                   misoOut,
  output logic                   misoOen_n,
  input  wire logic              ssPin_n,
  output logic                   portActive
);
  import smsp_pkg::*;

  initial
  begin
    if (SYNC_STAGES != 2)
      $error("Synchroniser depth must be 2.");
  end

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [7:0]  ctrl_reg;
  logic        done_reg, write_collision_flag_reg, ovr_reg, mode_fault_flag_reg;
  logic [2:0]  sel_reg;         // Output disable, select management, internal select.
  logic [7:0]  rxBuf_reg;
  logic [7:0]  shift_reg;
  logic        statusSeen_reg;  // Status read since done or collision set.
  logic        ctrlSeen_reg;    // Control accessed while mode fault set.
  smsp_state_e state_reg;
  logic [3:0]  bitCnt_reg;
  logic [6:0]  divCnt_reg;
  logic        sckLvl_reg;
  logic        txBit_reg;
  logic [1:0]  sckSync, mosiSync, misoSync, ssSync;
  logic        sckPrev_reg;

  wire isMaster = ctrl_reg[`SMSP_CR_MASTER_SELECT_BIT];
  wire enabled  = ctrl_reg[`SMSP_CR_PEN];
  wire clock_polarity_bit     = ctrl_reg[`SMSP_CR_CLOCK_POLARITY_BIT];
  wire clock_phase_bit     = ctrl_reg[`SMSP_CR_CLOCK_PHASE_BIT];

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Two flops per pin; only the second stage is read elsewhere.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sckSync  <= 2'h0;
      mosiSync <= 2'h0;
      misoSync <= 2'h0;
      ssSync   <= 2'h3;
    end
    else
    begin
      sckSync  <= {sckSync[0], sckIn};
      mosiSync <= {mosiSync[0], mosiIn};
      misoSync <= {misoSync[0], misoIn};
      ssSync   <= {ssSync[0], ssPin_n};
    end
  end

  // Internal select: pin or software bit, low means selected.
  wire ssInt_n  = sel_reg[1] ? sel_reg[0] : ssSync[1];
  wire faultHit = enabled && isMaster && !ssInt_n;

  // Half-period in clocks, minus one: divide ratio over two.
  function automatic logic [6:0] halfDiv(input logic [2:0] sel);
    case (sel)
      3'b100:  halfDiv = 7'h01;  // Divide by 4.
      3'b000:  halfDiv = 7'h03;  // Divide by 8.
      3'b001:  halfDiv = 7'h07;  // Divide by 16.
      3'b110:  halfDiv = 7'h0F;  // Divide by 32.
      3'b010:  halfDiv = 7'h1F;  // Divide by 64.
      3'b011:  halfDiv = 7'h3F;  // Divide by 128.
      default: halfDiv = 7'h3F;  // Unlisted codes run slowest.
    endcase
  endfunction

  wire [6:0] halfCnt = halfDiv({ctrl_reg[`SMSP_CR_DIVEN], ctrl_reg[1:0]});

  // ------------------------------------------------------------
  // Edge sources
  // ------------------------------------------------------------
  wire busy      = (state_reg != SMSP_IDLE);
  wire mTick     = isMaster && busy && (divCnt_reg == halfCnt);
  wire sEdge     = !isMaster && enabled && !ssInt_n && (sckSync[1] != sckPrev_reg);
  wire slaveSel  = !isMaster && enabled && !ssInt_n;
  wire clkEdge   = isMaster ? mTick : sEdge;
  // Leading edge is away from idle level, trailing edge back to it.
  wire leadEdge  = clkEdge && (state_reg != SMSP_TRAIL);
  wire trailEdge = clkEdge && (state_reg == SMSP_TRAIL);
  wire rxPin     = isMaster ? misoSync[1] : mosiSync[1];
  // Phase 0 samples on leading edge, phase 1 on trailing edge.
  // Both roles read the same phase bit, and a slave takes the first edge it sees as leading,
  // so a matched pair of ends launches and captures on the same pair of edges.
  wire sampleNow = clock_phase_bit ? trailEdge : leadEdge;
  wire lastBit   = (bitCnt_reg == `SMSP_BITS_PER_BYTE - 4'h1);
  // Phase 0 ends on the last trailing edge, after the eighth sample.
  wire endByte   = trailEdge && lastBit;
  wire dataWr    = regWrite && regAddr == `SMSP_OFS_DATA;
  wire dataAcc   = (regWrite || regRead) && regAddr == `SMSP_OFS_DATA;
  wire wrBlocked = done_reg && !statusSeen_reg;
  wire startTx   = dataWr && !wrBlocked && isMaster && enabled && !busy;
  wire slaveLoad = dataWr && !wrBlocked && !isMaster && !busy;

  // ------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------
  // Each sampled bit enters the shift LSB; MSB goes out first.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg   <= SMSP_IDLE;
      bitCnt_reg  <= 4'h0;
      divCnt_reg  <= 7'h00;
      shift_reg   <= 8'h00;
      txBit_reg   <= 1'b0;
      sckLvl_reg  <= 1'b0;
      sckPrev_reg <= 1'b0;
    end
    else
    begin
      sckPrev_reg <= sckSync[1];
      if (!enabled || faultHit)
      begin
        state_reg  <= SMSP_IDLE;
        bitCnt_reg <= 4'h0;
        sckLvl_reg <= 1'b0;
      end
      else if (startTx || slaveLoad)
      begin
        shift_reg  <= regWdata;
        txBit_reg  <= regWdata[7];
        bitCnt_reg <= 4'h0;
        divCnt_reg <= 7'h00;
        state_reg  <= isMaster ? SMSP_LEAD : SMSP_IDLE;
      end
      else
      begin
        divCnt_reg <= mTick ? 7'h00 : (busy ? divCnt_reg + 7'h01 : 7'h00);
        // A slave arms itself on the first clock edge while selected.
        if (slaveSel && sEdge && state_reg == SMSP_IDLE)
          state_reg <= SMSP_TRAIL;
        else if (leadEdge && busy)
          state_reg <= SMSP_TRAIL;
        if (leadEdge)
          sckLvl_reg <= 1'b1;
        if (trailEdge)
        begin
          sckLvl_reg <= 1'b0;
          state_reg  <= endByte ? SMSP_IDLE : SMSP_LEAD;
          bitCnt_reg <= endByte ? 4'h0 : bitCnt_reg + 4'h1;
        end
        if (sampleNow)
          shift_reg <= {shift_reg[6:0], rxPin};
        // Launch the next bit on the edge opposite the sample.
        // In phase 0 the sample has already shifted the register, and in
        // phase 1 the launch comes before the shift, so the top bit is the
        // next one to go out in both cases.
        if (clock_phase_bit ? leadEdge : trailEdge)
          txBit_reg <= shift_reg[7];
      end
    end
  end

  // ------------------------------------------------------------
  // Master receive alignment
  // ------------------------------------------------------------
  // The return line reaches the logic two clocks after it moves on the pin.
  // At the fastest master rate the next sampling edge follows the launch
  // edge by only two clocks, so a sample on the nominal edge would still
  // see the bit before. The master therefore captures two clocks late,
  // once the synchronised line has settled, and closes the byte two clocks
  // late as well. A slave needs no delay: its clock passes the same flops
  // as its data, so both arrive together.
  // Limitation: a data write within two clocks of the last edge can start
  // a new byte before the done flag of the old one shows.
  logic [1:0] smpDly_reg;   // Delayed master sample strobes.
  logic [1:0] endDly_reg;   // Delayed master end-of-byte strobes.
  logic [7:0] rxSh_reg;     // Receive shifter, kept apart from transmit.

  wire rxShift = isMaster ? smpDly_reg[1] : sampleNow;
  wire byteEnd = isMaster ? endDly_reg[1] : endByte;

  // Both strobe pipes restart when the port is switched off or faults, so
  // no late sample lands after a byte that was cut short.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      smpDly_reg <= 2'h0;
      endDly_reg <= 2'h0;
    end
    else if (!enabled || faultHit)
    begin
      smpDly_reg <= 2'h0;
      endDly_reg <= 2'h0;
    end
    else
    begin
      smpDly_reg <= {smpDly_reg[0], sampleNow && isMaster};
      endDly_reg <= {endDly_reg[0], endByte && isMaster};
    end
  end

  // Received bits enter at the bottom, so the first bit ends up on top.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rxSh_reg <= 8'h00;
    else if (rxShift)
      rxSh_reg <= {rxSh_reg[6:0], rxPin};
  end

  // ------------------------------------------------------------
  // Status flags and receive buffer
  // ------------------------------------------------------------
  wire stRead  = regRead && regAddr == `SMSP_OFS_STATUS;
  wire crAcc   = (regRead || regWrite) && regAddr == `SMSP_OFS_CONTROL;
  wire crWrite = regWrite && regAddr == `SMSP_OFS_CONTROL;
  // When the last capture falls on the closing cycle itself, the byte is
  // taken with that bit merged in; otherwise the shifter is already full.
  wire [7:0] rxByte = rxShift ? {rxSh_reg[6:0], rxPin} : rxSh_reg;

  // Set beats clear for every flag: a completing byte keeps done high.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      done_reg       <= 1'b0;
      write_collision_flag_reg       <= 1'b0;
      ovr_reg        <= 1'b0;
      statusSeen_reg <= 1'b0;
      rxBuf_reg      <= 8'h00;
    end
    else
    begin
      if (stRead)
        statusSeen_reg <= 1'b1;
      else if (dataAcc)
        statusSeen_reg <= 1'b0;
      if (dataAcc && statusSeen_reg)
      begin
        done_reg <= 1'b0;
        write_collision_flag_reg <= 1'b0;
      end
      if (stRead)
        ovr_reg <= 1'b0;
      if (dataWr && busy)
        write_collision_flag_reg <= 1'b1;
      if (byteEnd)
      begin
        if (done_reg && !(dataAcc && statusSeen_reg))
          ovr_reg <= 1'b1;
        else
          rxBuf_reg <= rxByte;
        done_reg       <= 1'b1;
        statusSeen_reg <= 1'b0;
      end
    end
  end

  // Mode fault clears on a control access seen while set, then a write.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_fault_flag_reg     <= 1'b0;
      ctrlSeen_reg <= 1'b0;
    end
    else if (faultHit)
    begin
      mode_fault_flag_reg     <= 1'b1;
      ctrlSeen_reg <= 1'b0;
    end
    else
    begin
      if (crWrite && ctrlSeen_reg)
        mode_fault_flag_reg <= 1'b0;
      if (crAcc && mode_fault_flag_reg)
        ctrlSeen_reg <= !(crWrite && ctrlSeen_reg);
    end
  end

  // ------------------------------------------------------------
  // Control and software-owned status bits
  // ------------------------------------------------------------
  // Lower control bits have no defined reset; zero is used here.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= `SMSP_CR_RESET;
      sel_reg  <= 3'h0;
    end
    else
    begin
      if (crWrite)
        ctrl_reg <= regWdata;
      if (regWrite && regAddr == `SMSP_OFS_STATUS)
        sel_reg <= regWdata[2:0];
      // Fault wins over a same-cycle control write.
      if (faultHit)
      begin
        ctrl_reg[`SMSP_CR_PEN]  <= 1'b0;
        ctrl_reg[`SMSP_CR_MASTER_SELECT_BIT] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Read port and interrupt
  // ------------------------------------------------------------
  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      regRdata <= 8'h00;
    else if (regRead)
    begin
      case (regAddr)
        `SMSP_OFS_CONTROL: regRdata <= ctrl_reg;
        `SMSP_OFS_STATUS:  regRdata <= {done_reg, write_collision_flag_reg, ovr_reg, mode_fault_flag_reg, 1'b0, sel_reg};
        `SMSP_OFS_DATA:    regRdata <= rxBuf_reg;
        default:           regRdata <= 8'h00;
      endcase
    end
    else
      regRdata <= 8'h00;
  end

  assign irq = ctrl_reg[`SMSP_CR_IRQEN] && (done_reg || mode_fault_flag_reg || ovr_reg);

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  // Enables are active low; the clock idles at the polarity level.
  assign portActive = enabled;
  assign sckOut     = sckLvl_reg ^ clock_polarity_bit;
  assign sckOen_n   = !(enabled && isMaster);
  assign mosiOut    = txBit_reg;
  assign misoOut    = txBit_reg;
  assign mosiOen_n  = !(enabled && isMaster && !sel_reg[2]);
  assign misoOen_n  = !(enabled && !isMaster && !sel_reg[2] && !ssInt_n);
endmodule

/* smsp_params.svh */
// Constants for the serial master/slave port: register offsets, field positions, reset values, timing.
// Assumes inclusion by the port module; holds definitions only.
//
// Notes on behaviour
// - With interrupt enable set, done, mode-fault or overrun flags raise the interrupt.
// - Port enable resets low; set connects pins; cleared by mode fault.
// - Master rate bits pick divide by 4, 8, 16, 32, 64 or 128.
// - Divider enable resets low; rate bits do nothing in slave mode.
// - Master select drives clock out, swaps data lines; cleared by mode fault.
// - Clock polarity sets clock idle level in master role; only the master drives the clock, a slave ignores the bit.
// - Phase 0 captures on first clock edge, phase 1 on second.
// - Both ends use the same polarity and phase settings.
// - Done flag sets at byte end; cleared by status read then data access.
// - While done is set, data writes are ignored until status is read.
// - Collision flag sets when data is written during a transfer.
// - Overrun sets when a byte completes with done still set; status read clears.
// - Mode fault sets on select low in master; control access then write clears.
// - Status resets to zero; bit 3 reserved and reads zero.
// - Output disable removes the data output from its pin.
// - Select management takes internal select from internal-select bit, pin ignored.
// - Master data write loads shift register and starts a byte.
// - Received byte copied to buffer at done; data reads return buffer.
`ifndef SMSP_PARAMS_SVH
`define SMSP_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define SMSP_OFS_CONTROL  2'h0
`define SMSP_OFS_STATUS   2'h1
`define SMSP_OFS_DATA     2'h2

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define SMSP_CR_IRQEN   7
`define SMSP_CR_PEN     6
`define SMSP_CR_DIVEN   5
`define SMSP_CR_MASTER_SELECT_BIT    4
`define SMSP_CR_CLOCK_POLARITY_BIT    3
`define SMSP_CR_CLOCK_PHASE_BIT    2
`define SMSP_SR_DONE    7
`define SMSP_SR_WRITE_COLLISION_FLAG    6
`define SMSP_SR_OVR     5
`define SMSP_SR_MODE_FAULT_FLAG    4
`define SMSP_SR_ODIS    2
`define SMSP_SR_SSM     1
`define SMSP_SR_SSI     0
`define SMSP_CR_RESET   8'h00
`define SMSP_SR_RESET   8'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SMSP_BITS_PER_BYTE 4'h8

`endif

/* smsp_pkg.sv */
// Types shared by the serial master/slave port.
// Assumes the params header sits in the same folder.
package smsp_pkg;
  typedef logic [1:0] smsp_addr_t;
  typedef logic [7:0] smsp_byte_t;
  typedef enum logic [1:0]
  {
    SMSP_IDLE  = 2'b00,
    SMSP_LEAD  = 2'b01,
    SMSP_TRAIL = 2'b10
  } smsp_state_e;
endpackage

/* smsp_port_chk.sv */
// Concurrent checks on the serial port's register and pin behaviour.
// Assumes binding onto smsp_port; only its ports are visible here.
`timescale 1ns/100ps
module smsp_port_chk
  import smsp_pkg::*;
#(
  parameter int SYNC_STAGES = 2
)
(
  input wire logic                 ref_clk,
  input wire logic                 rst,
  input wire smsp_pkg::smsp_addr_t regAddr,
  input wire smsp_pkg::smsp_byte_t regWdata,
  input wire logic                 regWrite,
  input wire logic                 regRead,
  input wire logic [7:0]           regRdata,
  input wire logic                 irq,
  input wire logic                 sckOut,
  input wire logic                 sckOen_n,
  input wire logic                 mosiOen_n,
  input wire logic                 misoOen_n,
  input wire logic                 ssPin_n,
  input wire logic                 portActive
);
  logic wrCtl;
  logic irqEn_reg;
  logic master_select_bit_reg;
  logic odis_reg;
  logic ssm_reg;
  logic ssi_reg;

  // ------------------------------------------------------------
  // Shadows of the bits that steer the pins
  // ------------------------------------------------------------
  // Fault clearing of the role bit is not tracked, so uses pair it with portActive.
  assign wrCtl = regWrite && regAddr == 2'h0;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      {irqEn_reg, master_select_bit_reg} <= 2'h0;
    else if (wrCtl)
      {irqEn_reg, master_select_bit_reg} <= {regWdata[7], regWdata[4]};
  // Status bits that software writes.
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      {odis_reg, ssm_reg, ssi_reg} <= 3'h0;
    else if (regWrite && regAddr == 2'h1)
      {odis_reg, ssm_reg, ssi_reg} <= regWdata[2:0];

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_PEN_WR: assert property (wrCtl |=> portActive == $past(regWdata[6]))
    else $error("port enable does not follow control write");
  AST_PINS_FREE: assert property (!portActive && !$past(portActive) |-> sckOen_n && mosiOen_n && misoOen_n)
    else $error("pin driven while port disabled");
  AST_MASTER_SELECT_BIT_DRV: assert property (wrCtl && regWdata[6] && regWdata[4] && ssPin_n |=> !sckOen_n && misoOen_n)
    else $error("master role does not drive clock");
  AST_SLV_IN: assert property (wrCtl && regWdata[6] && !regWdata[4] |=> sckOen_n && mosiOen_n)
    else $error("slave role drives clock or input line");
  AST_SCK_HOLD: assert property ($changed(sckOut) |=> $stable(sckOut))
    else $error("clock half period below two cycles");
  AST_IRQ_OFF: assert property (!irqEn_reg && !$past(irqEn_reg) |-> !irq)
    else $error("interrupt while disabled");
  AST_ODIS: assert property (odis_reg && $past(odis_reg) |-> mosiOen_n && misoOen_n)
    else $error("data output driven while disabled");
  AST_MODE_FAULT_FLAG: assert property (portActive && master_select_bit_reg && !ssm_reg && !ssPin_n |-> ##[1:6] !portActive)
    else $error("select low in master mode did not disable port");
  AST_SSM: assert property (portActive && ssm_reg && ssi_reg && !ssPin_n && !wrCtl |=> portActive)
    else $error("select pin not ignored under software select");
  AST_RSVD: assert property (regRead && regAddr == 2'h1 |=> !regRdata[3])
    else $error("reserved status bit reads set");
  cover property ($fell(portActive));
  cover property (irq);
  cover property ($rose(sckOut));
endmodule

bind smsp_port smsp_port_chk #(.SYNC_STAGES(SYNC_STAGES)) chk_u (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .irq(irq), .sckOut(sckOut),
  .sckOen_n(sckOen_n), .mosiOen_n(mosiOen_n), .misoOen_n(misoOen_n), .ssPin_n(ssPin_n), .portActive(portActive));

/* smsp_slave_model.sv */
// Behavioural external slave for mode-0 bytes with the port as master.
// Assumes the bench drives its select and the byte it answers with.
`timescale 1ns/100ps
module smsp_slave_model
(
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       selN,
  input  wire logic [7:0] txByte,
  output logic            miso,
  output logic [7:0]      rxByte
);
  logic [7:0] txSh = 8'h00;
  // Load the reply as select goes low.
  always @(negedge selN)
    txSh = txByte;
  // Capture on the rising edge, most significant bit first.
  always @(posedge sck)
    if (!selN)
      rxByte = {rxByte[6:0], mosi};
  // Launch the next bit on the falling edge.
  always @(negedge sck)
    if (!selN)
      txSh = {txSh[6:0], 1'b0};
  // Deselected, the line shows the inverse so a stale bit never passes as data.
  assign miso = selN ? ~txSh[7] : txSh[7];
endmodule

/* tb.sv */
// Bench for the serial port as master beside a behavioural slave.
// Assumes the design and model files compile first; one 200 MHz clock.
`timescale 1ns/100ps
module tb;
  import smsp_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  smsp_addr_t regAddr = 2'h0;
  smsp_byte_t regWdata = 8'h00;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic       ssPin_n = 1'b1;
  logic       slvSelN = 1'b1;
  logic [7:0] slvTx = 8'h00;
  logic [7:0] regRdata, slvRx, v;
  logic       irq, sckOut, sckOen_n, mosiOut, mosiOen_n, misoOut, misoOen_n, portActive, slvMiso;
  logic       sckW, mosiW, misoW;
  int         err_total = 0;
  int         cmp_count = 0;
  time        t0;
  int         divs[6] = '{4, 8, 16, 32, 64, 128};
  logic [7:0] rates[6] = '{8'h20, 8'h00, 8'h01, 8'h22, 8'h02, 8'h03};

  // Wire levels from the port's enables, the slave model has none; the clock line has a pull-down.
  assign sckW = sckOen_n ? 1'b0 : sckOut;
  assign mosiW = mosiOen_n ? ~mosiOut : mosiOut;
  assign misoW = misoOen_n ? slvMiso : misoOut;
  always #2.5 ref_clk = ~ref_clk;

  smsp_port dut_u (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .irq(irq), .sckIn(sckW), .sckOut(sckOut), .sckOen_n(sckOen_n),
    .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOen_n(mosiOen_n), .misoIn(misoW), .misoOut(misoOut),
    .misoOen_n(misoOen_n), .ssPin_n(ssPin_n), .portActive(portActive));
  smsp_slave_model slv_u (.sck(sckW), .mosi(mosiW), .selN(slvSelN), .txByte(slvTx), .miso(slvMiso),
    .rxByte(slvRx));

  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task rd(input logic [1:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(posedge ref_clk);
    v = regRdata;
  endtask
  task rck(input logic [1:0] a, input logic [7:0] e);
    rd(a);
    chk("register", v, e);
  endtask
  // The reply is set a cycle before select so the model loads it cleanly.
  task xfer(input logic [7:0] d, input logic [7:0] s);
    slvSelN <= 1'b1;
    slvTx <= s;
    @(posedge ref_clk);
    slvSelN <= 1'b0;
    wr(2'h2, d);
  endtask
  task wdone;
    int k;
    k = 0;
    v = 8'h00;
    while (v[7] !== 1'b1 && k < 600)
    begin
      rd(2'h1);
      k++;
    end
  endtask
  task wrap_up;
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rck(2'h0, 8'h00);
    rck(2'h1, 8'h00);
    rck(2'h3, 8'h00);
    wr(2'h0, 8'h40);
    @(negedge ref_clk);
    chk("clock enable", {7'h0, sckOen_n}, 8'h01);
    // Each listed rate code: one clock period, then a full byte both ways.
    for (int i = 0; i < 6; i++)
    begin
      wr(2'h0, 8'h50 | rates[i]);
      xfer(8'hA1 + 8'(i), 8'h3C ^ 8'(i));
      @(posedge sckOut);
      t0 = $time;
      @(posedge sckOut);
      chk("clock period", 8'(($time - t0) / 5), 8'(divs[i]));
      wdone();
      chk("status", v, 8'h80);
      rck(2'h2, 8'h3C ^ 8'(i));
      chk("slave byte", slvRx, 8'hA1 + 8'(i));
    end
    // A second write in mid-byte collides and loads nothing.
    wr(2'h0, 8'h70);
    xfer(8'hA5, 8'h69);
    wr(2'h2, 8'h3C);
    wdone();
    chk("status", v, 8'hC0);
    rck(2'h2, 8'h69);
    chk("slave byte", slvRx, 8'hA5);
    rck(2'h1, 8'h00);
    // With done still set and status unread, a data write is dropped.
    xfer(8'h5A, 8'h96);
    repeat (80) @(posedge ref_clk);
    wr(2'h2, 8'hFF);
    repeat (80) @(posedge ref_clk);
    wr(2'h0, 8'hF0);
    @(negedge ref_clk);
    chk("irq", {7'h0, irq}, 8'h01);
    wr(2'h0, 8'h70);
    @(negedge ref_clk);
    chk("irq", {7'h0, irq}, 8'h00);
    rck(2'h1, 8'h80);
    rck(2'h2, 8'h96);
    chk("slave byte", slvRx, 8'h5A);
    // Idle clock level follows polarity; the port is off while it changes.
    for (int i = 1; i >= 0; i--)
    begin
      wr(2'h0, 8'h00);
      wr(2'h0, 8'h50 | 8'(i << 3));
      repeat (4) @(posedge ref_clk);
      chk("clock idle", {7'h0, sckOut}, 8'(i));
    end
    wr(2'h1, 8'h04);
    @(negedge ref_clk);
    chk("data enable", {7'h0, mosiOen_n}, 8'h01);
    wr(2'h1, 8'h00);
    @(negedge ref_clk);
    chk("data enable", {7'h0, mosiOen_n}, 8'h00);
    // Select pulled low in master mode faults; then software select masks the pin.
    for (int i = 0; i < 2; i++)
    begin
      if (i == 1)
      begin
        wr(2'h1, 8'h03);
        wr(2'h0, 8'h50);
      end
      ssPin_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      ssPin_n <= 1'b1;
      @(negedge ref_clk);
      chk("port active", {7'h0, portActive}, 8'(i));
      rck(2'h1, i ? 8'h03 : 8'h10);
      rck(2'h0, i ? 8'h50 : 8'h00);
    end
    wr(2'h0, 8'h50);
    rck(2'h1, 8'h03);
    wrap_up();
  end

  // Whole run needs some 2500 cycles; the limit leaves a wide margin.
  initial
  begin
    #200000;
    err_total++;
    wrap_up();
  end
endmodule
